//--- hdl/los_pkg.sv
// constants shared by the lock-in output scaling datapath
// assumes a 10 MHz system clock and an APB register port
package los_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ  = 10_000_000;
  localparam int UPD_HZ  = 2_000_000;
  localparam int UPD_CYC = CLK_HZ / UPD_HZ;
  localparam logic [2:0] UPD_LAST = 3'(UPD_CYC - 1);
  // ****************************************
  // number formats
  // ****************************************
  localparam int FRAC_BITS = 15;
  localparam logic signed [15:0] FS_CODE = 16'sh7FFF;
  localparam int PH_FS     = 18000;
  localparam int AUX_UNIT  = 1000;
  localparam int PCT_FULL  = 100;
  localparam logic signed [10:0] OFF_MAX = 11'sd999;
  localparam int EXP_MID   = 10;
  localparam int EXP_HI    = 100;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SENS = 8'h04;
  localparam logic [7:0] A_OFFX = 8'h08;
  localparam logic [7:0] A_OFFY = 8'h0C;
  localparam logic [7:0] A_OFFR = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam int B_CH1_R   = 0;
  localparam int B_CH2_PH  = 1;
  localparam int B_RAT_X   = 2;
  localparam int B_RAT_Y   = 3;
  localparam int B_RAT_R   = 4;
  localparam int B_EXP_X   = 8;
  localparam int B_EXP_Y   = 10;
  localparam int B_EXP_R   = 12;
  localparam logic [1:0] EXP_BAD = 2'h3;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam logic [23:0] SENS_RST = 24'h00_8000;
endpackage : los_pkg

//--- hdl/los_chan.sv
// one X, Y or R scaling lane: offset, ratio, expand and clamp
// purely combinational; the caller registers the results
`timescale 1ns/1ns
module los_chan (
  input  wire logic signed [23:0] val,
  input  wire logic        [23:0] sens,
  input  wire logic signed [10:0] off_pct,
  input  wire logic               ratio_en,
  input  wire logic signed [15:0] aux,
  input  wire logic        [1:0]  exp_code,
  output logic signed      [15:0] out_code,
  output logic signed      [15:0] disp_code,
  output logic signed      [31:0] chart,
  output logic                    ovl
);
  logic signed [63:0] frac;
  logic signed [63:0] offq;
  logic signed [63:0] diff;
  logic signed [63:0] div;
  logic signed [63:0] rat;
  logic signed [63:0] mult;
  logic signed [63:0] expd;
  logic signed [63:0] mag;
  logic               bad_aux;
  logic               neg;

  function automatic logic signed [63:0] sat(input logic signed [63:0] x,
                                              input logic signed [63:0] lim);
    if (x > lim) begin
      sat = lim;
    end else if (x < -lim) begin
      sat = -lim;
    end else begin
      sat = x;
    end
  endfunction : sat

  always_comb begin
    // 1.0 of sensitivity is 2^15, so full scale lands on the top code
    frac    = (64'(val) <<< los_pkg::FRAC_BITS) / $signed({40'h0, sens}); // RL3
    offq    = (64'(off_pct) <<< los_pkg::FRAC_BITS) / 64'(los_pkg::PCT_FULL); // RL7
    diff    = frac - offq; // RL9
    bad_aux = ratio_en && (aux <= 16'sh0000);
    // a dead aux input would divide by zero; treat it as overload
    div     = (ratio_en && !bad_aux) ? 64'(aux) : 64'(los_pkg::AUX_UNIT); // RL10
    rat     = (diff * 64'(los_pkg::AUX_UNIT)) / div; // RL9
    case (exp_code)
      2'h1:    mult = 64'(los_pkg::EXP_MID); // RL8
      2'h2:    mult = 64'(los_pkg::EXP_HI);
      default: mult = 64'sd1;
    endcase
    expd = rat * mult;
    mag  = (val < 24'sh000000) ? -64'(val) : 64'(val);
    neg  = bad_aux ? (diff < 64'sd0) : (expd < 64'sd0);
    ovl  = (mag > 64'(sens)) || bad_aux || (expd > 64'(los_pkg::FS_CODE))
           || (expd < -64'(los_pkg::FS_CODE)); // RL4 RL20
    // pinned at the rail on overload, both output and readout
    if (ovl) begin
      out_code  = neg ? -los_pkg::FS_CODE : los_pkg::FS_CODE; // RL19 RL20
      disp_code = neg ? -los_pkg::FS_CODE : los_pkg::FS_CODE;
    end else begin
      out_code  = 16'(expd);
      disp_code = 16'(sat(rat, 64'(los_pkg::FS_CODE))); // RL15
    end
    // chart keeps offset and ratio, ignores expand and overload
    chart = 32'(sat(rat, 64'sh7FFF_FFFF)); // RL16
  end
endmodule : los_chan

//--- hdl/los_output_scaling.sv
// output scaling datapath of the lock-in: front, rear and display values
// assumes X, Y, R, phase and aux inputs come from logic on clk
//
// Behaviour
// RL1: both front outputs refresh at 2.0 MHz.
// RL2: front one carries X or R, front two Y or phase; X/Y equal rear.
// RL3: value equal to sensitivity gives full scale 10 V, X/Y bipolar.
// RL4: signal above sensitivity flags overload; raw measurement untouched.
// RL5: phase spans +-180 degrees, 18 degrees per volt on front two.
// RL6: phase ignores sensitivity, range, offset, ratio and expand.
// RL7: offsets kept as percent of sensitivity, +-999, survive sensitivity change.
// RL8: expand is 1, 10 or 100 only.
// RL9: output = (value/sens - offset) / (ratio/1 V) * expand * 10 V, clamped.
// RL10: ratio divides X/Y by aux three, R by aux four, else by one.
// RL11: any ratio enabled lights the ratio lamp.
// RL12: R keeps its own offset, ratio and expand, apart from X/Y.
// RL13: displays, charts and queries carry offset and ratio.
// RL14: non-zero offset and non-unity ratio light display indicators.
// RL15: readout is value minus offset, expand only marks resolution.
// RL16: bar graphs follow expanded output; charts skip expand.
// RL17: X, Y and R are RMS quantities throughout.
// RL18: sensitivity scales bar graphs and readouts too.
// RL19: on overload output, bar and readout pin at maximum.
// RL20: negative results clamp at -10 V with overload set.
`timescale 1ns/1ns
module los_output_scaling (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic        [7:0]  paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic        [31:0] pwdata,
  output logic             [31:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [23:0] in_x,
  input  wire logic signed [23:0] in_y,
  input  wire logic signed [23:0] in_r,
  input  wire logic signed [15:0] in_phase,
  input  wire logic signed [15:0] aux_three,
  input  wire logic signed [15:0] aux_four,
  output logic signed      [15:0] front_output_one,
  output logic signed      [15:0] front_output_two,
  output logic signed      [15:0] rear_x,
  output logic signed      [15:0] rear_y,
  output logic                    update_strobe,
  output logic signed      [15:0] bar_x,
  output logic signed      [15:0] bar_y,
  output logic signed      [15:0] bar_r,
  output logic signed      [15:0] disp_x,
  output logic signed      [15:0] disp_y,
  output logic signed      [15:0] disp_r,
  output logic signed      [15:0] disp_phase,
  output logic signed      [31:0] chart_x,
  output logic signed      [31:0] chart_y,
  output logic signed      [31:0] chart_r,
  output logic             [5:0]  disp_resolution,
  output logic             [2:0]  ind_offset,
  output logic             [2:0]  ind_ratio,
  output logic             [2:0]  ind_expand,
  output logic                    ratio_lamp,
  output logic             [2:0]  overload
);
  // ****************************************
  // register file
  // ****************************************
  logic        [13:0] ctrl_reg, ctrl_next;
  logic        [23:0] sens_reg, sens_next;
  logic signed [10:0] offx_reg, offx_next;
  logic signed [10:0] offy_reg, offy_next;
  logic signed [10:0] offr_reg, offr_next;
  logic        [31:0] prdata_reg, prdata_next;
  logic               pready_reg, pready_next;
  logic               pslverr_reg, pslverr_next;
  logic               wr_done;
  logic               mapped;
  logic signed [15:0] wr_off;
  logic signed [10:0] off_clip;
  logic        [1:0]  ex_w, ey_w, er_w;
  logic        [31:0] stat_word;

  assign wr_done = psel && penable && pready_reg && pwrite;
  assign mapped  = (paddr == los_pkg::A_CTRL) || (paddr == los_pkg::A_SENS)
                || (paddr == los_pkg::A_OFFX) || (paddr == los_pkg::A_OFFY)
                || (paddr == los_pkg::A_OFFR) || (paddr == los_pkg::A_STAT);
  assign wr_off  = pwdata[15:0];
  // out-of-range offsets are clipped rather than wrapped
  assign off_clip = (wr_off > 16'(los_pkg::OFF_MAX)) ? los_pkg::OFF_MAX :
                    (wr_off < -16'(los_pkg::OFF_MAX)) ? -los_pkg::OFF_MAX :
                    11'(wr_off); // RL7
  assign ex_w = pwdata[los_pkg::B_EXP_X +: 2];
  assign ey_w = pwdata[los_pkg::B_EXP_Y +: 2];
  assign er_w = pwdata[los_pkg::B_EXP_R +: 2];

  always_comb begin
    ctrl_next    = ctrl_reg;
    sens_next    = sens_reg;
    offx_next    = offx_reg;
    offy_next    = offy_reg;
    offr_next    = offr_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    pready_next  = 1'b0;
    if (psel && penable && !pready_reg) begin
      pready_next  = 1'b1;
      pslverr_next = !mapped;
      case (paddr)
        los_pkg::A_CTRL: prdata_next = {18'h0, ctrl_reg};
        los_pkg::A_SENS: prdata_next = {8'h0, sens_reg};
        los_pkg::A_OFFX: prdata_next = 32'(offx_reg);
        los_pkg::A_OFFY: prdata_next = 32'(offy_reg);
        los_pkg::A_OFFR: prdata_next = 32'(offr_reg);
        los_pkg::A_STAT: prdata_next = stat_word;
        default:         prdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_done) begin
      case (paddr)
        los_pkg::A_CTRL: begin
          ctrl_next[4:0] = pwdata[4:0];
          // the fourth expand code is refused; the field keeps its value
          if (ex_w != los_pkg::EXP_BAD) ctrl_next[los_pkg::B_EXP_X +: 2] = ex_w; // RL8
          if (ey_w != los_pkg::EXP_BAD) ctrl_next[los_pkg::B_EXP_Y +: 2] = ey_w;
          if (er_w != los_pkg::EXP_BAD) ctrl_next[los_pkg::B_EXP_R +: 2] = er_w;
        end
        // zero sensitivity would divide by zero; ignored
        los_pkg::A_SENS: if (pwdata[23:0] != 24'h0) sens_next = pwdata[23:0];
        los_pkg::A_OFFX: offx_next = off_clip;
        los_pkg::A_OFFY: offy_next = off_clip;
        los_pkg::A_OFFR: offr_next = off_clip;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg    <= los_pkg::CTRL_RST;
      sens_reg    <= los_pkg::SENS_RST;
      offx_reg    <= 11'sh000;
      offy_reg    <= 11'sh000;
      offr_reg    <= 11'sh000;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      sens_reg    <= sens_next;
      offx_reg    <= offx_next;
      offy_reg    <= offy_next;
      offr_reg    <= offr_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // scaling lanes, RMS values in, RMS values out
  // ****************************************
  logic signed [15:0] ox, oy, orr, dx, dy, dr;
  logic signed [31:0] cx, cy, cr;
  logic        [2:0]  ovl_c;

  // R lane gets only its own offset, ratio and expand
  los_chan u_x (.val(in_x), .sens(sens_reg), .off_pct(offx_reg),
    .ratio_en(ctrl_reg[los_pkg::B_RAT_X]), .aux(aux_three),
    .exp_code(ctrl_reg[los_pkg::B_EXP_X +: 2]), .out_code(ox), .disp_code(dx),
    .chart(cx), .ovl(ovl_c[0])); // RL10 RL17
  los_chan u_y (.val(in_y), .sens(sens_reg), .off_pct(offy_reg),
    .ratio_en(ctrl_reg[los_pkg::B_RAT_Y]), .aux(aux_three),
    .exp_code(ctrl_reg[los_pkg::B_EXP_Y +: 2]), .out_code(oy), .disp_code(dy),
    .chart(cy), .ovl(ovl_c[1]));
  los_chan u_r (.val(in_r), .sens(sens_reg), .off_pct(offr_reg),
    .ratio_en(ctrl_reg[los_pkg::B_RAT_R]), .aux(aux_four),
    .exp_code(ctrl_reg[los_pkg::B_EXP_R +: 2]), .out_code(orr), .disp_code(dr),
    .chart(cr), .ovl(ovl_c[2])); // RL12

  // ****************************************
  // update pacing and output registers
  // ****************************************
  logic        [2:0]  cnt_reg, cnt_next;
  logic               tick;
  logic signed [15:0] ph_code;
  logic signed [15:0] f1_reg, f1_next, f2_reg, f2_next;
  logic signed [15:0] rx_reg, rx_next, ry_reg, ry_next;
  logic signed [15:0] bx_reg, by_reg, br_reg, dxr, dyr, drr, dph_reg;
  logic signed [31:0] cx_reg, cy_reg, cr_reg;
  logic               upd_reg;
  logic        [2:0]  ovl_reg, ind_off_reg, ind_rat_reg, ind_exp_reg;
  logic        [2:0]  ind_off_c, ind_rat_c, ind_exp_c;
  logic               lamp_reg;
  logic        [5:0]  res_reg;

  assign stat_word = {19'h0, ind_exp_reg, ind_rat_reg, ind_off_reg, lamp_reg, ovl_reg};

  assign tick = (cnt_reg == los_pkg::UPD_LAST);
  // phase in hundredths of a degree; 180 degrees is the top code
  assign ph_code = 16'((32'(in_phase) * 32'(los_pkg::FS_CODE)) / los_pkg::PH_FS); // RL5 RL6
  assign ind_off_c = {offr_reg != 11'sh0, offy_reg != 11'sh0, offx_reg != 11'sh0}; // RL14
  assign ind_rat_c = {ctrl_reg[los_pkg::B_RAT_R] && aux_four != 16'(los_pkg::AUX_UNIT),
                      ctrl_reg[los_pkg::B_RAT_Y] && aux_three != 16'(los_pkg::AUX_UNIT),
                      ctrl_reg[los_pkg::B_RAT_X] && aux_three != 16'(los_pkg::AUX_UNIT)};
  assign ind_exp_c = {ctrl_reg[los_pkg::B_EXP_R +: 2] != 2'h0,
                      ctrl_reg[los_pkg::B_EXP_Y +: 2] != 2'h0,
                      ctrl_reg[los_pkg::B_EXP_X +: 2] != 2'h0}; // RL15

  always_comb begin
    cnt_next = tick ? 3'h0 : cnt_reg + 3'h1; // RL1
    rx_next  = tick ? ox : rx_reg;
    ry_next  = tick ? oy : ry_reg;
    f1_next  = f1_reg;
    f2_next  = f2_reg;
    if (tick) begin
      f1_next = ctrl_reg[los_pkg::B_CH1_R] ? orr : ox; // RL2
      f2_next = ctrl_reg[los_pkg::B_CH2_PH] ? ph_code : oy; // RL2 RL5
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg     <= 3'h0;
      f1_reg      <= 16'sh0000;
      f2_reg      <= 16'sh0000;
      rx_reg      <= 16'sh0000;
      ry_reg      <= 16'sh0000;
      upd_reg     <= 1'b0;
      bx_reg      <= 16'sh0000;
      by_reg      <= 16'sh0000;
      br_reg      <= 16'sh0000;
      dxr         <= 16'sh0000;
      dyr         <= 16'sh0000;
      drr         <= 16'sh0000;
      dph_reg     <= 16'sh0000;
      cx_reg      <= 32'sh0000_0000;
      cy_reg      <= 32'sh0000_0000;
      cr_reg      <= 32'sh0000_0000;
      ovl_reg     <= 3'h0;
      ind_off_reg <= 3'h0;
      ind_rat_reg <= 3'h0;
      ind_exp_reg <= 3'h0;
      lamp_reg    <= 1'b0;
      res_reg     <= 6'h00;
    end else begin
      cnt_reg     <= cnt_next;
      f1_reg      <= f1_next;
      f2_reg      <= f2_next;
      rx_reg      <= rx_next;
      ry_reg      <= ry_next;
      upd_reg     <= tick;
      // bars track the expanded output, readouts only offset and ratio
      bx_reg      <= ox; // RL16 RL18
      by_reg      <= oy;
      br_reg      <= orr;
      dxr         <= dx; // RL13 RL15
      dyr         <= dy;
      drr         <= dr;
      dph_reg     <= in_phase; // RL6
      cx_reg      <= cx; // RL13 RL16
      cy_reg      <= cy;
      cr_reg      <= cr;
      ovl_reg     <= ovl_c; // RL4
      ind_off_reg <= ind_off_c;
      ind_rat_reg <= ind_rat_c;
      ind_exp_reg <= ind_exp_c;
      lamp_reg    <= |ctrl_reg[los_pkg::B_RAT_R:los_pkg::B_RAT_X]; // RL11
      res_reg     <= ctrl_reg[los_pkg::B_EXP_R+1:los_pkg::B_EXP_X];
    end
  end

  assign front_output_one = f1_reg;
  assign front_output_two = f2_reg;
  assign rear_x           = rx_reg;
  assign rear_y           = ry_reg;
  assign update_strobe    = upd_reg;
  assign bar_x            = bx_reg;
  assign bar_y            = by_reg;
  assign bar_r            = br_reg;
  assign disp_x           = dxr;
  assign disp_y           = dyr;
  assign disp_r           = drr;
  assign disp_phase       = dph_reg;
  assign chart_x          = cx_reg;
  assign chart_y          = cy_reg;
  assign chart_r          = cr_reg;
  assign disp_resolution  = res_reg;
  assign ind_offset       = ind_off_reg;
  assign ind_ratio        = ind_rat_reg;
  assign ind_expand       = ind_exp_reg;
  assign ratio_lamp       = lamp_reg;
  assign overload         = ovl_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_TICK_PERIOD: assert property (upd_reg |=> !upd_reg [*4] ##1 upd_reg) // RL1
    else $error("update strobe not every five cycles");
  AST_FRONT_ONE_X: assert property (upd_reg && !ctrl_reg[los_pkg::B_CH1_R]
    && $stable(ctrl_reg) |-> f1_reg == rx_reg) // RL2
    else $error("front one differs from rear x");
  AST_FRONT_TWO_Y: assert property (tick && !ctrl_reg[los_pkg::B_CH2_PH]
    |=> f2_reg == ry_reg) // RL2
    else $error("front two differs from rear y");
  AST_FULL_SCALE: assert property (tick && in_x == $signed({1'b0, sens_reg[22:0]})
    && !sens_reg[23] && offx_reg == 11'sh0 && !ctrl_reg[los_pkg::B_RAT_X]
    && ctrl_reg[los_pkg::B_EXP_X +: 2] == 2'h0 |=> rx_reg == los_pkg::FS_CODE) // RL3
    else $error("sensitivity input not at full scale");
  AST_OVERLOAD: assert property (in_r > $signed({1'b0, sens_reg}) |=> overload[2]) // RL4
    else $error("r above sensitivity not flagged");
  AST_PHASE_TOP: assert property (tick && ctrl_reg[los_pkg::B_CH2_PH]
    && in_phase == 16'(los_pkg::PH_FS) |=> f2_reg == los_pkg::FS_CODE) // RL5
    else $error("180 degrees not at full scale");
  AST_OFF_KEEP: assert property ($changed(sens_reg) |-> $stable(offx_reg)
    && $stable(offr_reg)) // RL7
    else $error("offset moved with sensitivity");
  AST_EXP_LEGAL: assert property (ctrl_reg[los_pkg::B_EXP_X +: 2] != los_pkg::EXP_BAD
    && ctrl_reg[los_pkg::B_EXP_R +: 2] != los_pkg::EXP_BAD) // RL8
    else $error("illegal expand code held");
  AST_CLAMP: assert property (rx_reg <= los_pkg::FS_CODE
    && rx_reg >= -los_pkg::FS_CODE) // RL9 RL20
    else $error("rear x beyond 10 V");
  AST_LAMP: assert property (ctrl_reg[los_pkg::B_RAT_R] |=> ratio_lamp) // RL11
    else $error("ratio lamp dark");
  AST_PIN: assert property (overload[0] |-> (bar_x == los_pkg::FS_CODE
    || bar_x == -los_pkg::FS_CODE) && (disp_x == los_pkg::FS_CODE
    || disp_x == -los_pkg::FS_CODE)) // RL19
    else $error("overloaded x not pinned");

  COV_PHASE_OUT: cover property (upd_reg && ctrl_reg[los_pkg::B_CH2_PH]);
  COV_OVERLOAD:  cover property ($rose(overload[0]));
  COV_RATIO_R:   cover property (ind_ratio[2] && ind_expand[2]);
endmodule : los_output_scaling

//--- tb/los_dac_model.sv
// behavioural model of the output converters behind the scaling block
// assumes update_strobe marks a freshly loaded front output pair
`timescale 1ns/1ns
module los_dac_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               update_strobe,
  input  wire logic signed [15:0] front_output_one,
  input  wire logic signed [15:0] front_output_two,
  output logic             [15:0] dac_one,
  output logic             [15:0] dac_two,
  output logic             [7:0]  last_gap
);
  logic [7:0] gap_cnt;
  // converters latch on the strobe only, as the real ones would
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_cnt  <= 8'h00;
      last_gap <= 8'h00;
      dac_one  <= 16'h0000;
      dac_two  <= 16'h0000;
    end else if (update_strobe) begin
      gap_cnt  <= 8'h01;
      last_gap <= gap_cnt;
      dac_one  <= front_output_one;
      dac_two  <= front_output_two;
    end else begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end
endmodule : los_dac_model

//--- tb/tb_top.sv
// self-checking bench for the lock-in output scaling block
// assumes the apb map and number formats of los_pkg
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [15:0] ctrl, off;
    logic [23:0] x, r;
    logic [15:0] a3, a4, bx, dx;
    logic [31:0] cx;
    logic [15:0] br;
    logic [2:0]  ovl;
  } los_row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, update_strobe, ratio_lamp;
  logic [7:0] paddr, last_gap;
  logic [31:0] pwdata, prdata, rd;
  logic signed [23:0] in_x, in_y, in_r;
  logic signed [15:0] in_phase, aux_three, aux_four, fo1, fo2, rear_x, rear_y;
  logic signed [15:0] bar_x, bar_y, bar_r, disp_x, disp_y, disp_r, disp_phase;
  logic signed [31:0] chart_x, chart_y, chart_r;
  logic [5:0] disp_resolution;
  logic [2:0] ind_offset, ind_ratio, ind_expand, overload;
  logic [15:0] dac_one, dac_two;
  logic er;
  int bad_count, checks_done;
  los_row_t rows [8] = '{
    '{16'h0000, 16'd0, 24'd16384, 24'd16384, 16'd1000, 16'd1000, 16'h4000, 16'h4000, 32'h4000, 16'h4000, 3'h0},
    '{16'h0100, 16'd0, 24'd1000, 24'd1000, 16'd1000, 16'd1000, 16'h2710, 16'h03E8, 32'h03E8, 16'h03E8, 3'h0},
    '{16'h0200, 16'd0, 24'd1000, 24'd1000, 16'd1000, 16'd1000, 16'h7FFF, 16'h7FFF, 32'h03E8, 16'h03E8, 3'h1},
    '{16'h0000, 16'd10, 24'd16384, 24'd8192, 16'd1000, 16'd1000, 16'h3334, 16'h3334, 32'h3334, 16'h2000, 3'h0},
    '{16'h0200, 16'd0, 24'hFFC000, 24'd0, 16'd1000, 16'd1000, 16'h8001, 16'h8001, 32'hFFFFC000, 16'h0000, 3'h1},
    '{16'h001C, 16'd0, 24'd16384, 24'd8192, 16'd2000, 16'd4000, 16'h2000, 16'h2000, 32'h2000, 16'h0800, 3'h0},
    '{16'h0000, 16'd0, 24'd40000, 24'd0, 16'd1000, 16'd1000, 16'h7FFF, 16'h7FFF, 32'h9C40, 16'h0000, 3'h1},
    '{16'h2000, 16'd0, 24'd100, 24'd200, 16'd1000, 16'd1000, 16'h0064, 16'h0064, 32'h0064, 16'h4E20, 3'h0}};
  los_output_scaling i_los_output_scaling (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_x(in_x), .in_y(in_y), .in_r(in_r), .in_phase(in_phase),
    .aux_three(aux_three), .aux_four(aux_four), .front_output_one(fo1), .front_output_two(fo2),
    .rear_x(rear_x), .rear_y(rear_y), .update_strobe(update_strobe), .bar_x(bar_x),
    .bar_y(bar_y), .bar_r(bar_r), .disp_x(disp_x), .disp_y(disp_y), .disp_r(disp_r),
    .disp_phase(disp_phase), .chart_x(chart_x), .chart_y(chart_y), .chart_r(chart_r),
    .disp_resolution(disp_resolution), .ind_offset(ind_offset), .ind_ratio(ind_ratio),
    .ind_expand(ind_expand), .ratio_lamp(ratio_lamp), .overload(overload));
  los_dac_model i_los_dac_model (.clk(clk), .rst(rst), .update_strobe(update_strobe),
    .front_output_one(fo1), .front_output_two(fo2), .dac_one(dac_one), .dac_two(dac_two),
    .last_gap(last_gap));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is sampled high; one idle cycle after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // settled inputs reach the converters at the next update after one edge
  task automatic wait_upd;
    int n;
    @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (update_strobe !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      final_report();
    end
    @(posedge clk);
  endtask : wait_upd
  task automatic drive(input logic [23:0] x, input logic [23:0] r, input logic [15:0] ph);
    in_x <= x;
    in_y <= x;
    in_r <= r;
    in_phase <= ph;
  endtask : drive
  initial begin
    bad_count = 0;
    checks_done = 0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {in_x, in_y, in_r, in_phase, aux_three, aux_four} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // ****************************************
    // table of ordinary scaling cases
    // ****************************************
    foreach (rows[i]) begin
      apb(1'b1, los_pkg::A_CTRL, {16'h0000, rows[i].ctrl});
      apb(1'b1, los_pkg::A_OFFX, {16'h0000, rows[i].off});
      drive(rows[i].x, rows[i].r, 16'h0000);
      aux_three <= rows[i].a3;
      aux_four <= rows[i].a4;
      wait_upd();
      chk($unsigned(bar_x), rows[i].bx);
      chk($unsigned(disp_x), rows[i].dx);
      chk($unsigned(chart_x), rows[i].cx);
      chk($unsigned(bar_r), rows[i].br);
      chk(overload[0], rows[i].ovl[0]);
      chk(dac_one, rows[i].bx);
      chk($unsigned(rear_x), rows[i].bx);
    end
    // ****************************************
    // awkward cases
    // ****************************************
    apb(1'b0, los_pkg::A_STAT, 32'h0);
    chk(rd[0], 1'b0);
    chk(last_gap, 8'(los_pkg::UPD_CYC));
    apb(1'b1, los_pkg::A_CTRL, 32'h0000_0003);
    drive(24'd16384, 24'd16384, 16'sd18000);
    wait_upd();
    chk(dac_one, 16'h4000);
    chk(dac_two, 16'h7FFF);
    chk({rear_y, bar_y}, 32'h4000_4000);
    chk({disp_y, disp_r}, 32'h4000_4000);
    chk(chart_y, 32'h0000_4000);
    chk(chart_r, 32'h0000_4000);
    apb(1'b1, los_pkg::A_SENS, 32'h0001_0000);
    apb(1'b1, los_pkg::A_OFFX, 32'h0000_000A);
    drive(24'd32768, 24'd16384, -16'sd9000);
    wait_upd();
    chk(dac_two, 16'hC001);
    chk($unsigned(disp_phase), 16'hDCD8);
    chk($unsigned(bar_x), 16'h3334);
    chk($unsigned(bar_r), 16'h2000);
    apb(1'b1, los_pkg::A_SENS, 32'h0);
    apb(1'b0, los_pkg::A_SENS, 32'h0);
    chk(rd, 32'h0001_0000);
    apb(1'b1, los_pkg::A_OFFX, 32'h0000_FC18);
    apb(1'b0, los_pkg::A_OFFX, 32'h0);
    chk(rd[10:0], 11'h419);
    apb(1'b1, los_pkg::A_CTRL, 32'h0000_0104);
    aux_three <= 16'sd2000;
    apb(1'b1, los_pkg::A_CTRL, 32'h0000_0304);
    @(posedge clk);
    chk({ratio_lamp, ind_expand, ind_ratio, ind_offset}, 10'h249);
    chk(disp_resolution, 6'h01);
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    // second reset mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({ratio_lamp, overload, fo1}, 20'h0);
    apb(1'b0, los_pkg::A_SENS, 32'h0);
    chk(rd, 32'h0000_8000);
    apb(1'b0, los_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h0);
    final_report();
  end
endmodule : tb_top
